// file: include/hwi_regs.svh
// register offsets, bit positions and reset values of the hardware interrupt group
`ifndef HWI_REGS_SVH
`define HWI_REGS_SVH
// register offsets on the host register address
`define HWI_OFS_PENDING 7'h06
`define HWI_OFS_ENABLE 7'h0F
`define HWI_OFS_OUT_EN 7'h13
// common source bits
`define HWI_BIT_FRAMING 15
`define HWI_BIT_EEPROM_CHECKSUM_ERROR 14
`define HWI_BIT_RAM_PARITY_FAIL 13
`define HWI_BIT_RT 2
`define HWI_BIT_MT 1
// read-only field of the enable register, bits 4..0
`define HWI_EN_RO_MASK 16'h001F
// writable bits of the pending register, 15..3
`define HWI_PEND_RW_MASK 16'hFFF8
// implemented source bits 15..13
`define HWI_SRC_MASK 16'hE000
// reset values
`define HWI_EN_RST 16'h4000
`define HWI_OE_RST 16'h4000
`define HWI_PEND_RST 16'h0000
// master status ram-init-fail bit position
`define HWI_MSR_RAM_INIT_FAIL 1
`endif

// file: include/hwi_pkg.sv
// types shared by the hardware interrupt register files
package hwi_pkg;
	// register selector, one-hot
	typedef enum logic [3:0] {
		HWI_SEL_NONE = 4'h1,
		HWI_SEL_PEND = 4'h2,
		HWI_SEL_EN = 4'h4,
		HWI_SEL_OE = 4'h8
	} hwi_sel_t;
	// sixteen-bit register word
	typedef logic [15:0] hwi_word_t;
endpackage

// file: logic/hwi_sync.sv
// two-flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module hwi_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	// first stage, read only by the second stage
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	// next values of both stages
	// no reset here: the strap must reach the capture flop during reset
	always_comb
	begin
		next_meta = d;
		next_q = meta;
	end

	// register both stages
	always_ff @(posedge clk)
	begin
		meta <= next_meta;
		q <= next_q;
	end
endmodule

// file: logic/hwi_regs_top.sv
// hardware interrupt enable, pending and output-enable registers
// Notes on behaviour
// - enable bits four to zero are read-only
// - pending bits two, one summarise RT, MT
// - bits fifteen to three share source meaning
// - bit fifteen flags host serial framing error
// - checksum error only with auto-init strapped high
// - checksum enable, output-enable bits reset to one
// - bit thirteen flags uncorrectable ram parity failure
// - parity error clears master status init-fail flag
// - all output-enabled pending interrupts ORed onto one request
`timescale 1ns/1ps
`include "hwi_regs.svh"
module hwi_regs_top
	import hwi_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic [6:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	input wire logic AUTO_INIT_SELECT,
	input wire logic HOST_SERIAL_FRAMING_ERROR,
	input wire logic EEPROM_CHECKSUM_ERROR,
	input wire logic RAM_PARITY_FAIL,
	input wire logic RAM_INIT_FAIL_SET,
	input wire logic RT_PENDING_ANY,
	input wire logic MT_PENDING_ANY,
	output logic RAM_INIT_FAIL,
	output logic AUTO_INIT_ENABLED,
	output logic IRQ_B
);
	// synchronised copy of the auto-init strap pin
	logic auto_pin;
	// registers
	hwi_word_t enable, next_enable;
	hwi_word_t pending, next_pending;
	hwi_word_t out_en, next_out_en;
	logic ram_init_fail, next_ram_init_fail;
	logic auto_init, next_auto_init;
	// strap capture happens in first cycle after reset release
	logic in_reset, next_in_reset;
	hwi_word_t rdata, next_rdata;
	logic irq, next_irq;
	// decoded selector and source events
	hwi_sel_t wsel, rsel;
	hwi_word_t events;

	// decode an address into a register selector
	function automatic hwi_sel_t decode(input logic [6:0] a);
		unique case (a)
			`HWI_OFS_PENDING: decode = HWI_SEL_PEND;
			`HWI_OFS_ENABLE: decode = HWI_SEL_EN;
			`HWI_OFS_OUT_EN: decode = HWI_SEL_OE;
			default: decode = HWI_SEL_NONE;
		endcase
	endfunction

	// strap pin synchroniser
	hwi_sync #(
		.WIDTH(1)
	) u_sync (
		.clk(CORE_CLK),
		.d(AUTO_INIT_SELECT),
		.q(auto_pin)
	);

	assign wsel = REG_WR ? decode(REG_ADDR) : HWI_SEL_NONE;
	assign rsel = decode(REG_ADDR);

	// event vector in common source layout
	always_comb
	begin
		events = '0;
		events[`HWI_BIT_FRAMING] = HOST_SERIAL_FRAMING_ERROR;
		events[`HWI_BIT_EEPROM_CHECKSUM_ERROR] = EEPROM_CHECKSUM_ERROR & auto_init;
		events[`HWI_BIT_RAM_PARITY_FAIL] = RAM_PARITY_FAIL | RAM_INIT_FAIL_SET;
	end

	// next values of all register state
	always_comb
	begin
		next_enable = enable;
		next_out_en = out_en;
		next_pending = pending;
		next_ram_init_fail = ram_init_fail;
		next_auto_init = auto_init;
		next_in_reset = 1'b0;
		next_rdata = rdata;
		next_irq = 1'b0;
		// strap captured one cycle after release, after sync
		if (in_reset)
		begin
			next_auto_init = auto_pin;
		end
		if (wsel == HWI_SEL_EN)
		begin
			next_enable = (REG_WDATA & ~`HWI_EN_RO_MASK)
				| (enable & `HWI_EN_RO_MASK);
		end
		// same low-bit protection on output enable
		if (wsel == HWI_SEL_OE)
		begin
			next_out_en = (REG_WDATA & ~`HWI_EN_RO_MASK)
				| (out_en & `HWI_EN_RO_MASK);
		end
		// host writes one to clear pending source bits
		if (wsel == HWI_SEL_PEND)
		begin
			next_pending = pending & ~(REG_WDATA & `HWI_PEND_RW_MASK);
		end
		// set wins over clear, only enabled sources latch
		next_pending = next_pending | (events & enable & `HWI_SRC_MASK);
		// summary bits follow terminal pending levels
		next_pending[`HWI_BIT_RT] = RT_PENDING_ANY;
		next_pending[`HWI_BIT_MT] = MT_PENDING_ANY;
		next_pending[0] = 1'b0;
		// parity clears init fail, init fail set otherwise
		if (RAM_PARITY_FAIL)
		begin
			next_ram_init_fail = 1'b0;
		end
		else if (RAM_INIT_FAIL_SET)
		begin
			next_ram_init_fail = 1'b1;
		end
		// registered read data
		if (REG_RD)
		begin
			unique case (rsel)
				HWI_SEL_PEND: next_rdata = pending;
				HWI_SEL_EN: next_rdata = enable;
				HWI_SEL_OE: next_rdata = out_en;
				HWI_SEL_NONE: next_rdata = 16'h0000;
			endcase
		end
		next_irq = |(pending & out_en);
		if (!RST_B)
		begin
			next_enable = `HWI_EN_RST;
			next_out_en = `HWI_OE_RST;
			next_pending = `HWI_PEND_RST;
			next_ram_init_fail = 1'b0;
			next_auto_init = 1'b0;
			next_in_reset = 1'b1;
			next_rdata = 16'h0000;
			next_irq = 1'b0;
		end
	end

	// register all state
	always_ff @(posedge CORE_CLK)
	begin
		enable <= next_enable;
		out_en <= next_out_en;
		pending <= next_pending;
		ram_init_fail <= next_ram_init_fail;
		auto_init <= next_auto_init;
		in_reset <= next_in_reset;
		rdata <= next_rdata;
		irq <= next_irq;
	end

	// outputs
	assign REG_RDATA = rdata;
	assign RAM_INIT_FAIL = ram_init_fail;
	assign AUTO_INIT_ENABLED = auto_init;
	assign IRQ_B = ~irq;

	property p_en_ro;
		@(posedge CORE_CLK) disable iff (!RST_B)
		$past(RST_B) |-> (enable[4:0] == $past(enable[4:0]));
	endproperty
	a_en_ro: assert property (p_en_ro)
		else $error("enable low bits changed");

	property p_summary;
		@(posedge CORE_CLK) disable iff (!RST_B)
		RT_PENDING_ANY && MT_PENDING_ANY |=> pending[2] && pending[1];
	endproperty
	a_summary: assert property (p_summary)
		else $error("summary bits not set");

	// write to pending cannot set RT summary bit two while RT is low
	property p_common;
		@(posedge CORE_CLK) disable iff (!RST_B)
		(wsel == HWI_SEL_PEND) && !RT_PENDING_ANY |=> !pending[2];
	endproperty
	a_common: assert property (p_common)
		else $error("summary bit written by host");

	property p_framing;
		@(posedge CORE_CLK) disable iff (!RST_B)
		HOST_SERIAL_FRAMING_ERROR && enable[15] |=> pending[15];
	endproperty
	a_framing: assert property (p_framing)
		else $error("framing error not flagged");

	property p_eeprom_checksum_error;
		@(posedge CORE_CLK) disable iff (!RST_B)
		!auto_init && !$past(pending[14]) && $past(RST_B)
			|-> !pending[14];
	endproperty
	a_eeprom_checksum_error: assert property (p_eeprom_checksum_error)
		else $error("checksum flag without auto-init");

	property p_rst;
		@(posedge CORE_CLK) !RST_B |=> enable[14] && out_en[14];
	endproperty
	a_rst: assert property (p_rst)
		else $error("checksum enable not one after reset");

	sequence s_parity;
		RAM_PARITY_FAIL && enable[13];
	endsequence
	property p_parity;
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_parity |=> pending[13] && !ram_init_fail;
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity did not set flag or clear init fail");

	// request two cycles after enabled event
	property p_irq;
		@(posedge CORE_CLK) disable iff (!RST_B)
		HOST_SERIAL_FRAMING_ERROR && enable[15] && out_en[15]
			&& !REG_WR |=> ##1 !IRQ_B;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request not asserted");
endmodule

// file: sim/hwi_host.sv
// host model driving the register bus
`timescale 1ns/1ps
module hwi_host (
	input wire logic clk,
	output logic [6:0] addr,
	output logic wr,
	output logic rd,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic init_fail
);
	// bus idle at time zero
	initial
	begin
		addr = 7'h00;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 16'h0000;
	end
	// one-cycle write strobe, data scrambled after
	task automatic wr_word(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	// read, word taken one cycle after strobe
	task automatic rd_word(input logic [6:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	function automatic logic parity_cause();
		return ~init_fail;
	endfunction
endmodule

// file: sim/test_hw_interrupt_regs.sv
// self-checking bench for the hardware interrupt registers
`timescale 1ns/1ps
`include "hwi_regs.svh"
module test_hw_interrupt_regs
	import hwi_pkg::*;
	;
	typedef struct packed {
		logic [6:0] a;
		hwi_word_t w;
		hwi_word_t e;
	} hwi_row_t;
	logic clk = 1'b0; // core clock
	logic rst_b = 1'b0; // reset, low active
	logic strap = 1'b0; // auto-init strap
	logic [3:0] ev = 4'h0; // framing, checksum, parity, init
	logic rt = 1'b0;
	logic mt = 1'b0;
	logic [6:0] addr;
	logic wr;
	logic rd;
	hwi_word_t wdata;
	hwi_word_t rdata;
	hwi_word_t d;
	logic init_fail;
	logic auto_en;
	logic irq_b;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	// write, then read back expectation
	hwi_row_t rows [4] = '{
		'{`HWI_OFS_ENABLE, 16'h001F, 16'h0000},
		'{`HWI_OFS_ENABLE, 16'hFFFF, 16'hFFE0},
		'{`HWI_OFS_OUT_EN, 16'hE000, 16'hE000},
		'{7'h10, 16'hFFFF, 16'h0000}
	};
	hwi_host u_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
		.wdata(wdata), .rdata(rdata), .init_fail(init_fail));
	hwi_regs_top u_dut (.CORE_CLK(clk), .RST_B(rst_b),
		.REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .AUTO_INIT_SELECT(strap),
		.HOST_SERIAL_FRAMING_ERROR(ev[3]), .EEPROM_CHECKSUM_ERROR(ev[2]),
		.RAM_PARITY_FAIL(ev[1]), .RAM_INIT_FAIL_SET(ev[0]),
		.RT_PENDING_ANY(rt), .MT_PENDING_ANY(mt),
		.RAM_INIT_FAIL(init_fail), .AUTO_INIT_ENABLED(auto_en),
		.IRQ_B(irq_b));
	// 4 ns clock
	always #2 clk = ~clk;
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	// compare one word
	task automatic chk(input hwi_word_t g, input hwi_word_t e);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// read a register and compare
	task automatic rchk(input logic [6:0] a, input hwi_word_t e);
		u_host.rd_word(a, d);
		chk(d, e);
	endtask
	// sixteen-cycle reset with strap level
	task automatic do_reset(input logic s);
		@(posedge clk);
		rst_b <= 1'b0;
		strap <= s;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// one-cycle event pulse, then settle
	task automatic pulse(input logic [3:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 4'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// verdict and end of run
	task automatic print_verdict();
		if (bad_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		do_reset(1'b0);
		rchk(`HWI_OFS_ENABLE, 16'h4000);
		rchk(`HWI_OFS_OUT_EN, 16'h4000);
		rchk(`HWI_OFS_PENDING, 16'h0000);
		chk({15'h0, irq_b}, 16'h0001);
		chk({15'h0, auto_en}, 16'h0000);
		foreach (rows[i])
		begin
			u_host.wr_word(rows[i].a, rows[i].w);
			rchk(rows[i].a, rows[i].e);
		end
		// checksum refused without strap
		pulse(4'h4);
		rchk(`HWI_OFS_PENDING, 16'h0000);
		pulse(4'h8);
		rchk(`HWI_OFS_PENDING, 16'h8000);
		chk({15'h0, irq_b}, 16'h0000);
		pulse(4'h1);
		chk({15'h0, init_fail}, 16'h0001);
		rchk(`HWI_OFS_PENDING, 16'hA000);
		pulse(4'h2);
		chk({15'h0, init_fail}, 16'h0000);
		chk({15'h0, u_host.parity_cause()}, 16'h0001);
		// clear sources one at a time
		u_host.wr_word(`HWI_OFS_PENDING, 16'h8000);
		rchk(`HWI_OFS_PENDING, 16'h2000);
		chk({15'h0, irq_b}, 16'h0000);
		u_host.wr_word(`HWI_OFS_PENDING, 16'h2000);
		rchk(`HWI_OFS_PENDING, 16'h0000);
		chk({15'h0, irq_b}, 16'h0001);
		// terminal summaries
		@(posedge clk);
		rt <= 1'b1;
		mt <= 1'b1;
		rchk(`HWI_OFS_PENDING, 16'h0006);
		@(posedge clk);
		rt <= 1'b0;
		rchk(`HWI_OFS_PENDING, 16'h0002);
		@(posedge clk);
		mt <= 1'b0;
		// strap high enables checksum source
		do_reset(1'b1);
		chk({15'h0, auto_en}, 16'h0001);
		pulse(4'h4);
		rchk(`HWI_OFS_PENDING, 16'h4000);
		chk({15'h0, irq_b}, 16'h0000);
		print_verdict();
	end
endmodule
